// ---- rtl/ft_sram_port.v ----
// Flow-through late-write SRAM port: command decode, burst counter, array, read FIFO
// Assumes all inputs synchronous to core_clk; pad tristate built outside
`timescale 1ns/1ps
`default_nettype none
`include "ft_sram_regs.vh"
module ft_sram_port (
    input wire core_clk,
    input wire sys_rst,
    input wire clock_hold_n,
    input wire advance_or_load,
    input wire read_not_write,
    input wire chip_select_0_n,
    input wire chip_select_1,
    input wire chip_select_2_n,
    input wire [`ADDR_W-1:0] addr,
    input wire [`LANES-1:0] byte_lane_write_n,
    input wire burst_order_select,
    input wire snooze_request,
    input wire output_enable_n,
    input wire [`DATA_W-1:0] dq_in,
    output reg [`DATA_W-1:0] dq_out,
    output wire dq_oe,
    output wire rd_valid,
    input wire rd_ready,
    output wire [`DATA_W-1:0] rd_data
);
    // =====================================================
    // Command stage
    // =====================================================
    wire step = clock_hold_n == 1'b0 && !snooze_request; // [RQ11] [RQ16]
    wire selected = !chip_select_0_n && chip_select_1 && !chip_select_2_n; // [RQ15]
    reg [1:0] op_reg;
    reg [`ADDR_W-1:0] base_reg;
    reg [1:0] cnt_reg;
    reg [1:0] cur_op_reg;
    reg [`ADDR_W-1:0] cur_addr_reg;
    reg [`LANES-1:0] cur_be_n_reg;
    reg [1:0] cnt_next;
    reg [1:0] op_next;
    reg [`ADDR_W-1:0] addr_next;
    always @* begin
        cnt_next = cnt_reg + 2'h1;
        op_next = op_reg;
        addr_next = cur_addr_reg;
        if (!advance_or_load) begin
            // Load new operation and address
            cnt_next = 2'h0; // [RQ14]
            if (!selected) begin
                op_next = `OP_DESEL; // [RQ8]
            end else if (read_not_write) begin
                op_next = `OP_READ; // [RQ4]
            end else begin
                op_next = `OP_WRITE; // [RQ4]
            end
            addr_next = addr; // [RQ6] [RQ12]
        end else begin
            // Continue last operation; address, chip selects and read-not-write ignored
            if (burst_order_select) begin
                addr_next = {base_reg[`ADDR_W-1:2], base_reg[1:0] ^ cnt_next}; // [RQ9] [RQ13]
            end else begin
                addr_next = {base_reg[`ADDR_W-1:2], base_reg[1:0] + cnt_next}; // [RQ13]
            end
        end
    end
    always @(posedge core_clk) begin
        if (sys_rst) begin
            op_reg <= `OP_DESEL;
            base_reg <= {`ADDR_W{1'b0}};
            cnt_reg <= 2'h0;
            cur_op_reg <= `OP_DESEL;
            cur_addr_reg <= {`ADDR_W{1'b0}};
            cur_be_n_reg <= {`LANES{1'b1}};
        end else if (snooze_request) begin
            cur_op_reg <= `OP_DESEL; // [RQ16]
        end else if (step) begin
            op_reg <= op_next; // [RQ10]
            cnt_reg <= cnt_next;
            if (!advance_or_load) begin
                base_reg <= addr;
            end
            cur_op_reg <= op_next; // [RQ10]
            cur_addr_reg <= addr_next;
            cur_be_n_reg <= byte_lane_write_n; // [RQ6]
        end
    end
    // =====================================================
    // Array: write data taken one cycle after command
    // =====================================================
    reg [`LANE_W-1:0] lane0 [0:`WORDS-1];
    reg [`LANE_W-1:0] lane1 [0:`WORDS-1];
    reg [`LANE_W-1:0] lane2 [0:`WORDS-1];
    reg [`LANE_W-1:0] lane3 [0:`WORDS-1];
    wire do_write = step && cur_op_reg == `OP_WRITE; // [RQ1] [RQ2] [RQ3]
    always @(posedge core_clk) begin
        if (do_write) begin
            if (!cur_be_n_reg[0]) lane0[cur_addr_reg] <= dq_in[8:0]; // [RQ5] [RQ17]
            if (!cur_be_n_reg[1]) lane1[cur_addr_reg] <= dq_in[17:9]; // [RQ5] [RQ17]
            if (!cur_be_n_reg[2]) lane2[cur_addr_reg] <= dq_in[26:18]; // [RQ5] [RQ17]
            if (!cur_be_n_reg[3]) lane3[cur_addr_reg] <= dq_in[35:27]; // [RQ5] [RQ17]
        end
    end
    // Flow-through read: data shown during the cycle after the command
    always @* begin
        dq_out = {lane3[cur_addr_reg], lane2[cur_addr_reg], lane1[cur_addr_reg], lane0[cur_addr_reg]};
    end
    wire reading = cur_op_reg == `OP_READ && !sys_rst;
    assign dq_oe = reading && !output_enable_n && !snooze_request; // [RQ7] [RQ8] [RQ16]
    // =====================================================
    // Read capture FIFO toward the user side
    // =====================================================
    wire fifo_in_ready;
    sync_fifo #(
        .WIDTH(`DATA_W),
        .DEPTH(`FIFO_DEPTH),
        .AW(`FIFO_AW)
    ) u_rd_fifo (
        .clk(core_clk),
        .rst(sys_rst),
        .in_valid(reading && step && fifo_in_ready),
        .in_ready(fifo_in_ready),
        .in_data(dq_out),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data)
    );
endmodule
`default_nettype wire

// ---- rtl/ft_sram_regs.vh ----
// Constants for the flow-through late-write SRAM port
// Assumes a single core clock; included by bare name
// What this block does
// RQ1: The master puts write data on the bus one cycle after the write command, and it is captured at that edge.
// RQ2: Write data latency is one cycle, the same as the flow-through read latency.
// RQ3: Reads and writes follow each other on consecutive cycles with no idle turnaround.
// RQ4: A load with read-not-write low starts a write, high starts a read.
// RQ5: Each byte write enable gates its own lane, and all low writes the whole word.
// RQ6: Write enables and the write address are registered on a rising edge.
// RQ7: The master may hold output enable active all the time, since drivers are managed inside.
// RQ8: Any deselecting chip select floats the data outputs.
// RQ9: While advancing, address, chip selects and read-not-write are ignored and the counter steps in the chosen order.
// RQ10: Advancing continues the last loaded operation: burst read, burst write or deselect.
// RQ11: Clock hold high makes the edge ignored and freezes all operations.
// RQ12: The array holds 262144 words of 36 bits, addressed by the registered address.
// RQ13: Burst order select high gives interleaved order, low gives linear order modulo four.
// RQ14: Advance-or-load low loads a new address and samples chip selects and read-not-write.
// RQ15: Chip selects are sampled only at loads; selected means cs0 low, cs1 high, cs2 low.
// RQ16: Snooze high ignores all other inputs and floats outputs.
// RQ17: The data bus is four byte lanes of 9 bits, each governed by its byte write enable.
`ifndef FT_SRAM_REGS_VH
`define FT_SRAM_REGS_VH
`define ADDR_W 18
`define WORDS 262144
`define LANES 4
`define LANE_W 9
`define DATA_W 36
`define FIFO_DEPTH 16
`define FIFO_AW 4
`define OP_DESEL 2'h0
`define OP_READ 2'h1
`define OP_WRITE 2'h2
`endif

// ---- rtl/sync_fifo.v ----
// Synchronous FIFO with valid/ready on both sides
// Assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module sync_fifo #(
    parameter WIDTH = 36,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk,
    input wire rst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr_reg;
    reg [AW:0] rd_ptr_reg;
    wire empty = (wr_ptr_reg == rd_ptr_reg);
    wire full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    always @* begin
        out_data = mem[rd_ptr_reg[AW-1:0]];
    end
    always @(posedge clk) begin
        if (in_valid && !full) begin
            mem[wr_ptr_reg[AW-1:0]] <= in_data;
        end
    end
    always @(posedge clk) begin
        if (rst) begin
            wr_ptr_reg <= {(AW+1){1'b0}};
            rd_ptr_reg <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && !full) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (out_ready && !empty) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ---- bench/ft_sram_port_monitor.sv ----
// Pin-level checker for the SRAM port
// Bound to the port from the bench top
`timescale 1ns/1ps
`default_nettype none
module ft_sram_port_monitor (input wire logic core_clk, sys_rst, clock_hold_n, advance_or_load,
    read_not_write, chip_select_0_n, chip_select_1, chip_select_2_n, snooze_request, output_enable_n,
    dq_oe, rd_valid, rd_ready, input wire logic [35:0] dq_out, rd_data);
    wire logic ld = !clock_hold_n && !snooze_request && !advance_or_load;
    wire logic sel = !chip_select_0_n && chip_select_1 && !chip_select_2_n;
    wire logic off = output_enable_n || snooze_request;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    property p_rd; ld && sel && read_not_write |=> dq_oe || off; endproperty
    a_rd: assert property (p_rd) else $error("read not driven");
    property p_ds; ld && !sel |=> !dq_oe; endproperty
    a_ds: assert property (p_ds) else $error("deselect driven");
    property p_wr; ld && sel && !read_not_write |=> !dq_oe; endproperty
    a_wr: assert property (p_wr) else $error("write slot driven");
    property p_oe; output_enable_n |-> !dq_oe; endproperty
    a_oe: assert property (p_oe) else $error("driven with oe off");
    property p_zz; snooze_request && $past(snooze_request) |-> !dq_oe; endproperty
    a_zz: assert property (p_zz) else $error("driven in snooze");
    property p_hold; clock_hold_n && !off |=> off || $stable(dq_out) && $stable(dq_oe); endproperty
    a_hold: assert property (p_hold) else $error("held edge moved data");
    property p_adv; !clock_hold_n && !snooze_request && advance_or_load && dq_oe |=> dq_oe || off; endproperty
    a_adv: assert property (p_adv) else $error("burst read dropped");
    property p_fifo; rd_valid && !rd_ready |=> rd_valid && $stable(rd_data); endproperty
    a_fifo: assert property (p_fifo) else $error("queued data moved");
endmodule
`default_nettype wire

// ---- bench/sram_bus_master.sv ----
// Bus master model: command on one edge, write data one cycle later
// Caller enters op one nanosecond after a rising edge
`timescale 1ns/1ps
`default_nettype none
module sram_bus_master (input wire logic core_clk, output logic advance_or_load, read_not_write,
    chip_select_0_n, chip_select_1, chip_select_2_n, output logic [17:0] addr,
    output logic [3:0] byte_lane_write_n, output logic [35:0] dq_in);
    logic wr = 1'b0;
    logic [35:0] wr_data = 36'h0;
    task automatic op(input logic ld, rnw, input logic [2:0] cs, input logic [17:0] a,
        input logic [3:0] be, input logic [35:0] d);
        advance_or_load = !ld;
        read_not_write = rnw;
        {chip_select_0_n, chip_select_1, chip_select_2_n} = cs;
        addr = a;
        byte_lane_write_n = be;
        dq_in = wr ? wr_data : ~wr_data;
        if (ld) wr = cs == 3'h2 && !rnw;
        wr_data = d;
        @(posedge core_clk) #1;
    endtask
    initial op(1'b1, 1'b1, 3'h6, 18'h0, 4'hF, 36'h0);
endmodule
`default_nettype wire

// ---- bench/ft_sram_port_tb.sv ----
// Bench for the SRAM port, master model on the pins
// Assumes model and monitor compiled first
`timescale 1ns/1ps
`default_nettype none
module ft_sram_port_tb;
    logic core_clk = 1'b0, sys_rst = 1'b1, clock_hold_n = 1'b0, burst_order_select = 1'b1;
    logic snooze_request = 1'b0, output_enable_n = 1'b0, rd_ready = 1'b0;
    wire logic advance_or_load, read_not_write, chip_select_0_n, chip_select_1, chip_select_2_n, dq_oe, rd_valid;
    wire logic [17:0] addr;
    wire logic [3:0] byte_lane_write_n;
    wire logic [35:0] dq_in, dq_out, rd_data;
    logic [35:0] q[$];
    int num_errors = 0, tests_run = 0;
    initial forever #4 core_clk = ~core_clk;
    sram_bus_master m (.*);
    ft_sram_port dut (.*);
    task chk(input logic [35:0] seen, exp);
        tests_run++;
        if (seen !== exp) num_errors++;
        if (seen !== exp) $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    endtask
    task beat(input logic [35:0] exp);
        chk(dq_oe, 1'b1);
        chk(dq_out, exp);
        q.push_back(exp);
    endtask
    task results;
        if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task t_late;
        m.op(1'b1, 1'b0, 3'h2, 18'h10, 4'h0, 36'h123456789);
        m.op(1'b1, 1'b1, 3'h2, 18'h10, 4'hF, 36'h0);
        beat(36'h123456789);
        m.op(1'b1, 1'b0, 3'h2, 18'h10, 4'hE, 36'hABCDEF012);
        m.op(1'b1, 1'b1, 3'h2, 18'h10, 4'hF, 36'h0);
        beat(36'h123456612);
        burst_order_select = 1'b0;
        for (int i = 0; i < 4; i++) m.op(i == 0, 1'b0, i == 0 ? 3'h2 : 3'h5, 18'h24, 4'h0, 36'hC0000000 + i);
    endtask
    task t_burst(input logic lin, input logic [1:0] s, input int hold_at);
        logic [1:0] o;
        burst_order_select = !lin;
        for (int i = 0; i < 8; i++) begin
            m.op(i == 0, 1'b1, i == 0 ? 3'h2 : 3'h5, 18'h24 | s, 4'hF, 36'h0);
            o = lin ? s + i[1:0] : s ^ i[1:0];
            beat(36'hC0000000 + o);
            if (i == hold_at) begin
                clock_hold_n = 1'b1;
                repeat (2) @(posedge core_clk) #1;
                chk(dq_out, 36'hC0000000 + o);
                clock_hold_n = 1'b0;
            end
        end
    endtask
    task t_stop;
        output_enable_n = 1'b1;
        m.op(1'b1, 1'b1, 3'h2, 18'h10, 4'hF, 36'h0);
        chk(dq_oe, 1'b0);
        output_enable_n = 1'b0;
        snooze_request = 1'b1;
        repeat (2) @(posedge core_clk) #1;
        chk(dq_oe, 1'b0);
        snooze_request = 1'b0;
        for (int k = 0; k < 3; k++) begin
            m.op(1'b1, 1'b1, k == 0 ? 3'h6 : k == 1 ? 3'h0 : 3'h3, 18'h10, 4'hF, 36'h0);
            chk(dq_oe, 1'b0);
        end
        m.op(1'b0, 1'b1, 3'h2, 18'h10, 4'hF, 36'h0);
        chk(dq_oe, 1'b0);
    endtask
    task t_drain;
        rd_ready = 1'b1;
        for (int i = 0; i < 16; i++) begin
            chk(rd_data, q[i]);
            @(posedge core_clk) #1;
        end
        chk(rd_valid, 1'b0);
    endtask
    initial begin
        repeat (20) @(posedge core_clk) #1;
        sys_rst = 1'b0;
        t_late;
        t_burst(1'b0, 2'h2, -1);
        t_burst(1'b1, 2'h3, 1);
        t_stop;
        t_drain;
        results;
    end
endmodule
bind ft_sram_port ft_sram_port_monitor mon (.*);
`default_nettype wire
